// [inc/hlt_map.svh]
// Functional notes
// [R01] Postscaled output pulses one timer clock when postscaler count equals postscale select.
// [R02] Postscaler counter advances on every count-equals-period match.
// [R03] Postscaled pulse also drives converter trigger and output-generator shutdown outputs.
// [R04] Live count and period-match signal are handed to the PWM compare unit.
// [R05] External reset input comes from source chosen by reset source select register.
// [R06] Five-bit mode field: upper two bits pick group, lower three the variant.
// [R07] Source must leave six timer clocks between edge triggers.
// [R08] Source must hold triggering level at least three timer clocks.
// [R09] External trigger activity is disregarded while debug freeze is active.
// [R10] Mode 00000: count while enabled, stop when cleared, no external effect.
// [R11] Modes 00001/00010: count only while enabled and input high/low.
// [R12] Modes 00011/00100/00101: enabled timer resets on any/rising/falling input edge.
// [R13] Modes 00110/00111: enabled timer held reset while input low/high.
// [R14] Mode 01000: single period started by software setting the enable bit.
// [R15] Modes 01001/01010/01011: one-shot starts on rising/falling/any edge once enabled.
// [R16] Modes 01100/01101: start on first edge, later same-polarity edges reset count.
// [R17] Mode 01110 rising start, low holds reset; 01111 falling start, high holds.
// [R18] Modes 10110/10111: start enabled with input high/low, opposite level holds reset.
// [R19] One-shot: clock after period match clears enable and stops count at 00h.
// [R20] Monostable 10001-10011: stop at 00h after match, enable stays set.
// [R21] Edge-started modes need a fresh edge after re-enabling before counting resumes.
// [R22] Count increments each timer clock, returns to zero the clock after period match.
// [R23] Device reset clears count and loads period with FFh.
// [R24] Postscaler cleared on count write, control write, reset, or external reset event.
// [R25] Reserved mode codes keep the timer stopped and ignore the external input.
`ifndef HLT_MAP_SVH
`define HLT_MAP_SVH
`define HLT_OFF_CTRL      8'h00
`define HLT_OFF_LIMIT     8'h04
`define HLT_OFF_RSTSEL    8'h08
`define HLT_OFF_COUNT     8'h0c
`define HLT_OFF_PERIOD    8'h10
`define HLT_OFF_STATUS    8'h14
`define HLT_CTRL_ON_BIT   0
`define HLT_CTRL_PS_LSB   4
`define HLT_CTRL_PS_MSB   7
`define HLT_ST_ON_BIT     0
`define HLT_ST_RUN_BIT    1
`define HLT_ST_START_BIT  2
`define HLT_ST_ERS_BIT    3
`define HLT_ST_PC_LSB     4
`define HLT_ST_PC_MSB     7
`define HLT_RST_PERIOD    8'hff
`define HLT_RST_COUNT     8'h00
`define HLT_RST_MODE      5'h00
`define HLT_RST_SEL       5'h00
`define HLT_RST_PS        4'h0
`endif

// [inc/hlt_pkg.sv]
package hlt_pkg;
	typedef logic [4:0] mode_t;
	typedef logic [7:0] byte_t;
	typedef struct packed {
		logic        on;
		logic [3:0]  post_sel;
		mode_t       mode;
		logic [4:0]  rst_sel;
		byte_t       count;
		byte_t       period;
		logic [3:0]  post_cnt;
		logic        ers_q;
		logic        ers_prev;
		logic        started;
		logic        pulse;
		logic        adc;
		logic        complementary_output_gen;
		logic        match_out;
		logic        running;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} state_t;
endpackage

// [rtl/hw_limit_timer_mode_control.sv]
`timescale 1ns/1ps
`include "hlt_map.svh"
module hw_limit_timer_mode_control (
	input  wire logic          pclk,                 // timer clock, 250 MHz
	input  wire logic          presetn,              // async reset, active low
	input  wire logic          psel,                 // apb select
	input  wire logic          penable,              // apb enable
	input  wire logic          pwrite,               // apb direction
	input  wire logic [7:0]    paddr,                // apb byte address
	input  wire logic [31:0]   pwdata,               // apb write data
	output logic      [31:0]   prdata,               // apb read data
	output logic               pready,               // apb ready
	output logic               pslverr,              // apb error, unmapped address
	input  wire logic [31:0]   ers_sources,          // candidate external reset sources
	input  wire logic          debug_freeze,         // debugger freeze active
	output logic               postscaled_pulse_out, // one-clock postscaled pulse
	output logic               adc_trigger_out,      // converter trigger copy
	output logic               cog_shutdown_out,     // output generator shutdown copy
	output hlt_pkg::byte_t     count_value,          // live count to compare unit
	output hlt_pkg::byte_t     period_value,         // period to compare unit
	output logic               period_match_out,     // period match to compare unit
	output logic               timer_running_out     // timer counted this clock
);
	import hlt_pkg::*;

	state_t s;
	state_t next_s;

	logic       ers_sel;
	logic       rise;
	logic       fall;
	logic       any_edge;
	logic [1:0] grp;
	logic [2:0] var_code;
	logic       gate;
	logic       rst_now;
	logic       start_edge;
	logic       edge_mode;
	logic       one_shot;
	logic       mono;
	logic       match;
	logic       wr;
	logic       setup_rd;
	logic       mapped;

	assign grp      = s.mode[4:3]; // R06
	assign var_code = s.mode[2:0]; // R06
	assign ers_sel  = ers_sources[s.rst_sel]; // R05
	assign rise     = s.ers_q & ~s.ers_prev;
	assign fall     = ~s.ers_q & s.ers_prev;
	assign any_edge = rise | fall;
	assign wr       = psel & penable & pwrite & s.pready;
	assign setup_rd = psel & ~penable;
	assign mapped   = (paddr == `HLT_OFF_CTRL) || (paddr == `HLT_OFF_LIMIT) ||
	                  (paddr == `HLT_OFF_RSTSEL) || (paddr == `HLT_OFF_COUNT) ||
	                  (paddr == `HLT_OFF_PERIOD) || (paddr == `HLT_OFF_STATUS);

	// mode decode: gate allows counting, rst_now forces count to zero
	always_comb begin
		gate       = 1'b0;
		rst_now    = 1'b0;
		start_edge = 1'b0;
		edge_mode  = 1'b0;
		one_shot   = 1'b0;
		mono       = 1'b0;
		case (s.mode)
			5'h00: gate = s.on; // R10
			5'h01: gate = s.on & s.ers_q; // R11
			5'h02: gate = s.on & ~s.ers_q; // R11
			5'h03: begin
				gate    = s.on;
				rst_now = s.on & any_edge; // R12
			end
			5'h04: begin
				gate    = s.on;
				rst_now = s.on & rise; // R12
			end
			5'h05: begin
				gate    = s.on;
				rst_now = s.on & fall; // R12
			end
			5'h06: begin
				gate    = s.on;
				rst_now = s.on & ~s.ers_q; // R13
			end
			5'h07: begin
				gate    = s.on;
				rst_now = s.on & s.ers_q; // R13
			end
			5'h08: begin
				gate     = s.on; // R14
				one_shot = 1'b1;
			end
			5'h09, 5'h11: begin
				edge_mode  = 1'b1;
				start_edge = rise; // R15
			end
			5'h0a, 5'h12: begin
				edge_mode  = 1'b1;
				start_edge = fall; // R15
			end
			5'h0b, 5'h13: begin
				edge_mode  = 1'b1;
				start_edge = any_edge; // R15
			end
			5'h0c: begin
				edge_mode  = 1'b1;
				start_edge = rise;
				rst_now    = s.on & s.started & rise; // R16
			end
			5'h0d: begin
				edge_mode  = 1'b1;
				start_edge = fall;
				rst_now    = s.on & s.started & fall; // R16
			end
			5'h0e: begin
				edge_mode  = 1'b1;
				start_edge = rise;
				rst_now    = s.on & s.started & ~s.ers_q; // R17
			end
			5'h0f: begin
				edge_mode  = 1'b1;
				start_edge = fall;
				rst_now    = s.on & s.started & s.ers_q; // R17
			end
			5'h16: begin
				gate     = s.on & s.ers_q; // R18
				rst_now  = s.on & ~s.ers_q; // R18
				one_shot = 1'b1;
			end
			5'h17: begin
				gate     = s.on & ~s.ers_q; // R18
				rst_now  = s.on & s.ers_q; // R18
				one_shot = 1'b1;
			end
			default: gate = 1'b0; // R25
		endcase
		if (edge_mode) begin
			gate     = s.on & s.started; // R21
			one_shot = (grp == 2'b01);
			mono     = (grp == 2'b10);
		end
	end

	assign match = gate & ~rst_now & (s.count == s.period);

	always_comb begin
		next_s           = s;
		next_s.pulse     = 1'b0;
		next_s.adc       = 1'b0;
		next_s.complementary_output_gen       = 1'b0;
		next_s.match_out = match; // R04
		next_s.running   = gate & ~rst_now;
		next_s.pready    = 1'b1;
		next_s.ers_prev  = s.ers_q;
		// frozen sample means no edge and no level change is seen
		if (!debug_freeze) begin
			next_s.ers_q = ers_sel; // R09
		end
		// a fresh edge is needed after every re-enable
		if (!s.on) begin
			next_s.started = 1'b0; // R21
		end else if (edge_mode && start_edge && !s.started) begin
			next_s.started = 1'b1; // R15
		end
		if (rst_now) begin
			next_s.count    = 8'h00; // R12
			next_s.post_cnt = 4'h0; // R24
		end else if (match) begin
			next_s.count = 8'h00; // R22
			if (s.post_cnt == s.post_sel) begin
				next_s.pulse    = 1'b1; // R01
				next_s.adc      = 1'b1; // R03
				next_s.complementary_output_gen      = 1'b1; // R03
				next_s.post_cnt = 4'h0;
			end else begin
				next_s.post_cnt = 4'(s.post_cnt + 4'h1); // R02
			end
			if (one_shot) begin
				next_s.on      = 1'b0; // R19
				next_s.started = 1'b0;
			end
			if (mono) begin
				next_s.started = 1'b0; // R20
			end
		end else if (gate) begin
			next_s.count = 8'(s.count + 8'h01); // R22
		end
		// software write lands last so a set of on beats the hardware clear
		if (wr) begin
			case (paddr)
				`HLT_OFF_CTRL: begin
					next_s.on       = pwdata[`HLT_CTRL_ON_BIT];
					next_s.post_sel = pwdata[`HLT_CTRL_PS_MSB:`HLT_CTRL_PS_LSB];
					next_s.post_cnt = 4'h0; // R24
				end
				`HLT_OFF_LIMIT:  next_s.mode = pwdata[4:0]; // R06
				`HLT_OFF_RSTSEL: next_s.rst_sel = pwdata[4:0]; // R05
				`HLT_OFF_COUNT: begin
					next_s.count    = pwdata[7:0];
					next_s.post_cnt = 4'h0; // R24
				end
				`HLT_OFF_PERIOD: next_s.period = pwdata[7:0];
				default:         next_s.period = s.period;
			endcase
		end
		// read data is captured in setup so the access phase needs no wait
		if (setup_rd) begin
			next_s.pslverr = ~mapped;
			next_s.prdata  = 32'h0000_0000;
			case (paddr)
				`HLT_OFF_CTRL: begin
					next_s.prdata[`HLT_CTRL_ON_BIT]                  = s.on;
					next_s.prdata[`HLT_CTRL_PS_MSB:`HLT_CTRL_PS_LSB] = s.post_sel;
				end
				`HLT_OFF_LIMIT:  next_s.prdata[4:0] = s.mode;
				`HLT_OFF_RSTSEL: next_s.prdata[4:0] = s.rst_sel;
				`HLT_OFF_COUNT:  next_s.prdata[7:0] = s.count;
				`HLT_OFF_PERIOD: next_s.prdata[7:0] = s.period;
				`HLT_OFF_STATUS: begin
					next_s.prdata[`HLT_ST_ON_BIT]                = s.on;
					next_s.prdata[`HLT_ST_RUN_BIT]               = s.running;
					next_s.prdata[`HLT_ST_START_BIT]             = s.started;
					next_s.prdata[`HLT_ST_ERS_BIT]               = s.ers_q;
					next_s.prdata[`HLT_ST_PC_MSB:`HLT_ST_PC_LSB] = s.post_cnt;
				end
				default: next_s.prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s          <= '0;
			s.count    <= `HLT_RST_COUNT; // R23
			s.period   <= `HLT_RST_PERIOD; // R23
			s.post_cnt <= `HLT_RST_PS; // R24
			s.post_sel <= `HLT_RST_PS;
			s.mode     <= `HLT_RST_MODE;
			s.rst_sel  <= `HLT_RST_SEL;
		end else begin
			s <= next_s;
		end
	end

	assign prdata               = s.prdata;
	assign pready               = s.pready;
	assign pslverr              = s.pslverr;
	assign postscaled_pulse_out = s.pulse;
	assign adc_trigger_out      = s.adc;
	assign cog_shutdown_out     = s.complementary_output_gen;
	assign count_value          = s.count;
	assign period_value         = s.period;
	assign period_match_out     = s.match_out;
	assign timer_running_out    = s.running;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_post_pulse;
		match && s.post_cnt == s.post_sel && !wr |=>
			s.pulse && s.post_cnt == 4'h0 ##1 !s.pulse || $past(match);
	endproperty
	a_post_pulse: assert property (p_post_pulse) else $error("postscaled pulse missing"); // R01

	property p_post_adv;
		match && s.post_cnt != s.post_sel && !wr |=> s.post_cnt == 4'($past(s.post_cnt) + 4'h1) && !s.pulse;
	endproperty
	a_post_adv: assert property (p_post_adv) else $error("postscaler did not advance"); // R02

	property p_side_copies;
		s.pulse |-> s.adc && s.complementary_output_gen && $past(match);
	endproperty
	a_side_copies: assert property (p_side_copies) else $error("trigger copies disagree"); // R03

	property p_match_out;
		match |=> period_match_out && count_value == 8'h00 || $past(wr);
	endproperty
	a_match_out: assert property (p_match_out) else $error("period match not passed on"); // R04

	property p_freeze;
		debug_freeze |=> $stable(s.ers_q) && !rise && !fall;
	endproperty
	a_freeze: assert property (p_freeze) else $error("trigger seen during freeze"); // R09

	property p_sw_gate;
		s.mode == 5'h00 && s.on && s.count != s.period && !wr |=> s.count == 8'($past(s.count) + 8'h01);
	endproperty
	a_sw_gate: assert property (p_sw_gate) else $error("software gate count wrong"); // R10

	property p_hw_gate;
		s.mode == 5'h01 && !s.ers_q && !wr |=> $stable(s.count);
	endproperty
	a_hw_gate: assert property (p_hw_gate) else $error("count moved with gate closed"); // R11

	property p_edge_rst;
		s.mode == 5'h04 && s.on && rise && !wr |=> s.count == 8'h00 && s.post_cnt == 4'h0;
	endproperty
	a_edge_rst: assert property (p_edge_rst) else $error("rising edge did not reset"); // R12

	property p_level_rst;
		s.mode == 5'h07 && s.on && s.ers_q && !wr |=> s.count == 8'h00 && !timer_running_out;
	endproperty
	a_level_rst: assert property (p_level_rst) else $error("high level did not hold reset"); // R13

	property p_one_shot_stop;
		grp == 2'b01 && match && !wr |=> !s.on && s.count == 8'h00 ##1 s.count == 8'h00 || $past(wr);
	endproperty
	a_one_shot_stop: assert property (p_one_shot_stop) else $error("one-shot did not stop"); // R19

	property p_mono_stop;
		mono && match && !wr |=> s.on && s.count == 8'h00 && !s.started;
	endproperty
	a_mono_stop: assert property (p_mono_stop) else $error("monostable stop wrong"); // R20

	property p_fresh_edge;
		edge_mode && !s.on |=> !s.started;
	endproperty
	a_fresh_edge: assert property (p_fresh_edge) else $error("start kept across disable"); // R21

	property p_reserved;
		(grp == 2'b11 || (grp == 2'b10 && var_code[2:1] == 2'b10)) && !wr |=> $stable(s.count);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved mode counted"); // R25

	// write cycles are kept in: a register write never changes the source sampled in that clock
	property p_src_select;
		!debug_freeze |=> s.ers_q == $past(ers_sel);
	endproperty
	a_src_select: assert property (p_src_select) else $error("wrong reset source sampled"); // R05

	property p_sw_start;
		s.mode == 5'h08 && s.on && !match && !wr |=> s.count == 8'($past(s.count) + 8'h01);
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("software one-shot not counting"); // R14

	property p_edge_start;
		s.mode == 5'h09 && s.on && !s.started && rise |=> s.started;
	endproperty
	a_edge_start: assert property (p_edge_start) else $error("rising edge did not start"); // R15

	property p_limit_edge;
		s.mode == 5'h0c && s.on && s.started && rise && !wr |=> s.count == 8'h00;
	endproperty
	a_limit_edge: assert property (p_limit_edge) else $error("later edge did not reset"); // R16

	property p_level_hold;
		s.mode == 5'h0e && s.on && s.started && !s.ers_q && !wr |=> s.count == 8'h00 && !timer_running_out;
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("low level did not hold reset"); // R17

	property p_level_one_shot;
		s.mode == 5'h16 && s.on && !s.ers_q && !wr |=> s.count == 8'h00;
	endproperty
	a_level_one_shot: assert property (p_level_one_shot) else $error("level one-shot not held"); // R18

	property p_count_step;
		gate && !rst_now && s.count != s.period && !wr |=> s.count == 8'($past(s.count) + 8'h01);
	endproperty
	a_count_step: assert property (p_count_step) else $error("count did not step"); // R22

	property p_post_clear;
		wr && (paddr == `HLT_OFF_CTRL || paddr == `HLT_OFF_COUNT) |=> s.post_cnt == 4'h0;
	endproperty
	a_post_clear: assert property (p_post_clear) else $error("postscaler kept on write"); // R24

	c_pulse:    cover property (s.pulse ##1 s.pulse);
	c_one_shot: cover property (grp == 2'b01 && match ##1 !s.on);
	c_mono:     cover property (mono && match ##[1:20] s.started);
	c_level:    cover property (s.mode == 5'h16 && rst_now ##1 gate);
endmodule

// [tb/ers_source_model.sv]
`timescale 1ns/1ps
module ers_source_model #(
	parameter int SEL = 3 // index of the source the bench selects
) (
	input  wire logic        pclk,        // timer clock
	input  wire logic        presetn,     // reset, active low
	input  wire logic        want,        // level the bench asks for
	output logic      [31:0] ers_sources, // candidate source lines
	output logic             settled      // asked level applied and held
);
	logic [7:0]  held;
	logic        lvl;
	logic [31:0] noise;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held  <= 8'h00;
			lvl   <= 1'b0;
			noise <= 32'h00000000;
		end else begin
			noise <= ~noise;
			// changes spaced at least seven clocks apart, so each level also lasts three
			if (want != lvl && held >= 8'h06) begin
				lvl  <= want;
				held <= 8'h00;
			end else if (held != 8'hff) begin
				held <= held + 8'h01;
			end
		end
	end
	always_comb begin
		ers_sources      = noise; // unselected lines never hold still
		ers_sources[SEL] = lvl;
	end
	assign settled = (want == lvl) && (held >= 8'h06);
endmodule

// [tb/hw_limit_timer_mode_control_tb_top.sv]
`timescale 1ns/1ps
`include "hlt_map.svh"
module hw_limit_timer_mode_control_tb_top;
	import hlt_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        debug_freeze = 1'b0;
	logic        want = 1'b0;
	logic [31:0] prdata, ers_sources, rdat;
	logic        pready, pslverr, rerr, pulse, adc, complementary_output_gen, match, running, settled;
	byte_t       count_value, period_value;
	int          n_errors = 0;
	int          checks = 0;
	// each entry: mode, running before the rise, running after it, count small after it
	logic [7:0]  modes [26] = '{8'h06, 8'h0b, 8'h14, 8'h1f, 8'h27, 8'h2e, 8'h33, 8'h3d,
		8'h46, 8'h4b, 8'h51, 8'h5b, 8'h63, 8'h69, 8'h73, 8'h79, 8'h81, 8'h8b, 8'h91,
		8'h9b, 8'ha1, 8'ha9, 8'hb3, 8'hbd, 8'hc1, 8'hf9};

	hw_limit_timer_mode_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ers_sources(ers_sources),
		.debug_freeze(debug_freeze), .postscaled_pulse_out(pulse), .adc_trigger_out(adc),
		.cog_shutdown_out(complementary_output_gen), .count_value(count_value), .period_value(period_value),
		.period_match_out(match), .timer_running_out(running));
	ers_source_model #(.SEL(3)) i_src (.pclk(pclk), .presetn(presetn), .want(want),
		.ers_sources(ers_sources), .settled(settled));

	always #2 pclk = ~pclk;

	task automatic wrap_up;
		if (n_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			n_errors++;
			wrap_up();
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge pclk);
	endtask
	task automatic lvl(input logic v);
		int n;
		@(posedge pclk);
		want <= v;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (settled !== 1'b1 && n < 30);
		if (n >= 30) begin
			n_errors++;
			wrap_up();
		end
		tick(1);
	endtask
	// timer off first so the new mode never sees a half-built setup
	task automatic setup(input logic [4:0] m, input logic [7:0] p, input logic [31:0] c);
		apb(1'b1, `HLT_OFF_CTRL, 32'h0);
		apb(1'b1, `HLT_OFF_LIMIT, {27'h0, m});
		apb(1'b1, `HLT_OFF_RSTSEL, 32'h3);
		apb(1'b1, `HLT_OFF_PERIOD, {24'h0, p});
		apb(1'b1, `HLT_OFF_COUNT, 32'h0);
		apb(1'b1, `HLT_OFF_CTRL, c);
	endtask

	task automatic s_reset;
		chk(count_value, 32'h0);
		chk(period_value, 32'hff);
		apb(1'b0, `HLT_OFF_PERIOD, 32'h0);
		chk(rdat, 32'hff);
		apb(1'b0, 8'h40, 32'h0);
		chk(rerr, 32'h1);
	endtask
	task automatic s_free;
		byte_t prev;
		int    n;
		int    np;
		lvl(1'b0);
		setup(5'h00, 8'h05, 32'h21);
		tick(1);
		chk(period_value, 32'h5);
		n = 0;
		while (match !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		if (n >= 20) begin
			n_errors++;
			wrap_up();
		end
		np = 0;
		prev = count_value;
		repeat (36) begin
			tick(1);
			chk(count_value, (prev == 8'h05) ? 32'h0 : prev + 8'h01);
			if (match === 1'b1) chk(count_value, 32'h0);
			chk({adc, complementary_output_gen}, {2{pulse}});
			np += pulse;
			prev = count_value;
		end
		chk(np, 2);
		apb(1'b1, `HLT_OFF_CTRL, 32'h0);
		apb(1'b1, `HLT_OFF_COUNT, 32'h3);
		tick(4);
		chk(count_value, 32'h3);
		apb(1'b0, `HLT_OFF_STATUS, 32'h0);
		chk(rdat[7:4], 32'h0);
	endtask
	task automatic s_modes;
		for (int i = 0; i < 26; i++) begin
			lvl(1'b0);
			setup(modes[i][7:3], 8'hff, 32'h1);
			tick(10);
			chk(running, modes[i][2]);
			lvl(1'b1);
			chk(running, modes[i][1]);
			chk(count_value < 8'd12, modes[i][0]);
		end
	endtask
	task automatic s_stops;
		lvl(1'b0);
		setup(5'h08, 8'h05, 32'h1);
		tick(15);
		chk(count_value, 32'h0);
		apb(1'b0, `HLT_OFF_CTRL, 32'h0);
		chk(rdat[0], 32'h0);
		setup(5'h11, 8'h20, 32'h1);
		lvl(1'b1);
		tick(45);
		chk(count_value, 32'h0);
		apb(1'b0, `HLT_OFF_CTRL, 32'h0);
		chk(rdat[0], 32'h1);
		lvl(1'b0);
		lvl(1'b1);
		chk(running, 32'h1);
	endtask
	task automatic s_rearm;
		lvl(1'b0);
		setup(5'h09, 8'hff, 32'h1);
		lvl(1'b1);
		apb(1'b1, `HLT_OFF_CTRL, 32'h0);
		apb(1'b1, `HLT_OFF_CTRL, 32'h1);
		tick(4);
		chk(running, 32'h0);
		lvl(1'b0);
		lvl(1'b1);
		chk(running, 32'h1);
	endtask
	task automatic s_freeze;
		lvl(1'b0);
		setup(5'h04, 8'hff, 32'h1);
		tick(30);
		@(posedge pclk);
		debug_freeze <= 1'b1;
		lvl(1'b1);
		lvl(1'b0);
		chk(count_value > 8'd30, 32'h1);
		@(posedge pclk);
		debug_freeze <= 1'b0;
		tick(4);
		chk(count_value > 8'd30, 32'h1);
	endtask

	initial begin
		repeat (100000) @(posedge pclk);
		n_errors++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		tick(1);
		s_reset();
		s_free();
		s_modes();
		s_stops();
		s_rearm();
		s_freeze();
		wrap_up();
	end
endmodule
